// File: dv/crsf_register_set_checker.sv
`timescale 1ns/100ps
module crsf_register_set_checker
(
   input wire        i_clock,
   input wire        i_rstn,
   input wire [3:0]  i_addr,
   input wire [15:0] i_wdata,
   input wire        i_wr,
   input wire        i_rd,
   input wire [1:0]  i_irq_level,
   input wire        i_irq_req,
   input wire [15:0] o_rdata,
   input wire [15:0] o_program_counter,
   input wire [15:0] o_gpr_address,
   input wire        o_irq_accept
);
   // ----------------
   // port properties
   // ----------------
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rstn);
   a_rdata_idle: assert property (!i_rd |=> o_rdata == 16'h0000) else $error("rdata not idle");
   a_pc_write: assert property (i_wr && i_addr == 4'h0 |=> o_program_counter == $past(i_wdata))
      else $error("pc write lost");
   a_pc_read: assert property (i_rd && i_addr == 4'h0 |=> o_rdata == $past(o_program_counter))
      else $error("pc read wrong");
   a_acc_back: assert property (i_wr && i_addr == 4'h1 ##1 i_rd && i_addr == 4'h1
      |=> o_rdata == $past(i_wdata, 2)) else $error("acc readback wrong");
   a_unmapped_rd: assert property (i_rd && i_addr > 4'h9 |=> o_rdata == 16'h0000)
      else $error("unmapped read not zero");
   a_irq_noreq: assert property (!i_irq_req |-> !o_irq_accept) else $error("accept without req");
   a_irq_reset: assert property ($rose(i_rstn) |-> !o_irq_accept) else $error("irq open at reset");
   a_lvl3_block: assert property (i_irq_level == 2'h3 |-> !o_irq_accept)
      else $error("level 3 accepted");
   a_gpr_window: assert property (o_gpr_address[15:8] == 8'h01) else $error("gpr addr range");
   c_status_rd: cover property (i_rd && i_addr == 4'h6);
   c_irq_taken: cover property (o_irq_accept);
   c_alu_op: cover property (i_wr && i_addr == 4'h7);
endmodule

// File: dv/crsf_register_set_tb.sv
`timescale 1ns/100ps
module crsf_register_set_tb;
   reg          i_clock     = 1'b0;
   reg          i_rstn      = 1'b0;
   reg  [3:0]   i_addr      = 4'h0;
   reg  [15:0]  i_wdata     = 16'h0000;
   reg          i_wr        = 1'b0;
   reg          i_rd        = 1'b0;
   reg  [1:0]   i_irq_level = 2'h0;
   reg          i_irq_req   = 1'b0;
   wire [15:0]  o_rdata;
   wire [15:0]  o_program_counter;
   wire [15:0]  o_gpr_address;
   wire         o_irq_accept;
   int          err_count   = 0;
   int          n_compared  = 0;
   int          i;
   logic [31:0] seed        = 32'h6342C1AE;
   logic [31:0] exp_q[$];
   logic        rd_seen     = 1'b0;
   logic [15:0] v;
   always #20 i_clock = ~i_clock;
   crsf_register_set uut (.i_clock, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .i_irq_level,
      .i_irq_req, .o_rdata, .o_program_counter, .o_gpr_address, .o_irq_accept);
   // ----------------
   // helpers
   // ----------------
   function logic [15:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[15:0];
   endfunction
   function logic [1:0] rk(input logic [1:0] c);
      return (c == 2'h0) ? 2'h1 : c;
   endfunction
   task cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e)
      begin
         err_count++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task bus(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
      i_wr <= w;
      i_rd <= r;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clock);
   endtask
   task wr(input logic [3:0] a, input logic [15:0] d);
      bus(1'b1, 1'b0, a, d);
   endtask
   task rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
      exp_q.push_back({m, e});
      bus(1'b0, 1'b1, a, 16'h0000);
   endtask
   task alu(input logic [2:0] op, input logic [15:0] a, t, r, f, m);
      wr(4'h1, a);
      wr(4'h2, t);
      wr(4'h7, {13'h0000, op});
      rd(4'h1, r, (op > 3'h3) ? 16'hFFFF : 16'h00FF);
      rd(4'h6, f, m);
   endtask
   task print_verdict;
      $display("compared %0d errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // ----------------
   // read monitor
   // ----------------
   always @(posedge i_clock)
   begin
      if (rd_seen)
      begin
         v = o_rdata;
         cmp("rdata", exp_q[0][15:0] & exp_q[0][31:16], v & exp_q[0][31:16]);
         void'(exp_q.pop_front());
      end
      rd_seen <= i_rd;
   end
   // ----------------
   // scenarios
   // ----------------
   initial
   begin
      repeat (4) @(posedge i_clock);
      i_rstn <= 1'b1;
      rd(4'h6, 16'h0030, 16'hFFFF);
      for (i = 0; i < 7; i++)
      begin
         v = rnd();
         wr(i[3:0], v);
         rd(i[3:0], v, 16'hFFFF);
      end
      for (i = 0; i < 32; i += 31)
      begin
         wr(4'h6, {i[7:0], 8'h00});
         wr(4'h8, 16'h075A);
         rd(4'h8, 16'h075A, 16'hFFFF);
         #1 cmp("gpr", 16'h0107 + 16'(i * 8), o_gpr_address);
      end
      wr(4'h6, 16'h0000);
      alu(3'h0, 16'h0080, 16'h0080, 16'h0000, 16'h0007, 16'h008F);
      alu(3'h0, 16'h000F, 16'h0001, 16'h0010, 16'h0080, 16'h008F);
      alu(3'h0, 16'h007F, 16'h0001, 16'h0080, 16'h008A, 16'h008F);
      alu(3'h1, 16'h0000, 16'h0001, 16'h00FF, 16'h0089, 16'h008F);
      alu(3'h2, 16'h0081, 16'h0000, 16'h0002, 16'h0001, 16'h000D);
      alu(3'h3, 16'h0001, 16'h0000, 16'h0000, 16'h0005, 16'h000D);
      alu(3'h4, 16'hFFFF, 16'h0001, 16'h0000, 16'h0004, 16'h0004);
      alu(3'h5, 16'h1234, 16'h0234, 16'h1000, 16'h0000, 16'h0004);
      wr(4'hA, rnd());
      rd(4'hA, 16'h0000, 16'hFFFF);
      for (i = 0; i < 64; i++)
      begin
         i_irq_level <= i[1:0];
         i_irq_req <= i[5];
         wr(4'h6, {9'h000, i[4], i[3:2], 4'h0});
         bus(1'b0, 1'b0, 4'h0, 16'h0000);
         #1 cmp("irq", {15'h0000, i[5] & i[4] & (rk(i[1:0]) < rk(i[3:2]))},
            {15'h0000, o_irq_accept});
      end
      repeat (3) @(posedge i_clock);
      print_verdict();
   end
   initial
   begin
      #100000;
      err_count++;
      print_verdict();
   end
endmodule
bind crsf_register_set crsf_register_set_checker chk (.i_clock, .i_rstn, .i_addr, .i_wdata,
   .i_wr, .i_rd, .i_irq_level, .i_irq_req, .o_rdata, .o_program_counter, .o_gpr_address,
   .o_irq_accept);

// File: hdl/crsf_register_set.v
`timescale 1ns/100ps
`include "crsf_defines.vh"
module crsf_register_set
(
   input  wire        i_clock,
   input  wire        i_rstn,
   input  wire [3:0]  i_addr,
   input  wire [15:0] i_wdata,
   input  wire        i_wr,
   input  wire        i_rd,
   input  wire [1:0]  i_irq_level,
   input  wire        i_irq_req,
   output reg  [15:0] o_rdata,
   output wire [15:0] o_program_counter,
   output wire [15:0] o_gpr_address,
   output wire        o_irq_accept
);
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   reg [15:0] pc_reg;
   reg [15:0] acc_reg;
   reg [15:0] tmp_reg;
   reg [15:0] idx_reg;
   reg [15:0] ext_reg;
   reg [15:0] sp_reg;
   reg [7:0]  bank_reg;
   reg [7:0]  flags_reg;
   reg [2:0]  gsel_reg;
   reg [7:0]  gpr_mem [0:255];
   reg [16:0] res;
   reg        hc;
   reg        ov;
   reg        cy;
   reg [7:0]  flags_next;
   wire [7:0] gpr_index;
   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   // rank of mask code: 00 and 01 both level 1
   function [1:0] crsf_rank;
      input [1:0] code;
      begin
         crsf_rank = (code == 2'h0) ? 2'h1 : code;
      end
   endfunction
   // ------------------------------------------------------------
   // alu on accumulator and temp (byte or word)
   // ------------------------------------------------------------
   always @*
   begin
      res = 17'h00000;
      hc  = 1'b0;
      ov  = 1'b0;
      cy  = 1'b0;
      flags_next = flags_reg;
      case (i_wdata[2:0])
         `CRSF_OP_ADD:
         begin
            res = {9'h000, acc_reg[7:0]} + {9'h000, tmp_reg[7:0]}; // see [RQ2] see [RQ3]
            hc  = ((acc_reg[3:0] + tmp_reg[3:0]) > 5'h0F) ? 1'b1 : 1'b0; // see [RQ8]
            cy  = res[8]; // see [RQ14]
            ov  = (acc_reg[7] == tmp_reg[7]) && (res[7] != acc_reg[7]); // see [RQ13]
         end
         `CRSF_OP_SUB:
         begin
            res = {9'h000, acc_reg[7:0]} - {9'h000, tmp_reg[7:0]};
            hc  = (acc_reg[3:0] < tmp_reg[3:0]) ? 1'b1 : 1'b0; // see [RQ8]
            cy  = res[8]; // see [RQ14]
            ov  = (acc_reg[7] != tmp_reg[7]) && (res[7] != acc_reg[7]); // see [RQ13]
         end
         `CRSF_OP_SHL:
         begin
            res = {9'h000, acc_reg[6:0], 1'b0};
            cy  = acc_reg[7]; // see [RQ15]
         end
         `CRSF_OP_SHR:
         begin
            res = {9'h000, 1'b0, acc_reg[7:1]};
            cy  = acc_reg[0]; // see [RQ15]
         end
         `CRSF_OP_ADDW:
         begin
            res = {1'b0, acc_reg} + {1'b0, tmp_reg};
            hc  = ((acc_reg[3:0] + tmp_reg[3:0]) > 5'h0F) ? 1'b1 : 1'b0;
            cy  = res[16];
            ov  = (acc_reg[15] == tmp_reg[15]) && (res[15] != acc_reg[15]);
         end
         default:
         begin
            res = {1'b0, acc_reg} - {1'b0, tmp_reg};
            hc  = (acc_reg[3:0] < tmp_reg[3:0]) ? 1'b1 : 1'b0;
            cy  = res[16];
            ov  = (acc_reg[15] != tmp_reg[15]) && (res[15] != acc_reg[15]);
         end
      endcase
      flags_next[`CRSF_F_H] = hc;
      flags_next[`CRSF_F_C] = cy;
      flags_next[`CRSF_F_V] = ov;
      if (i_wdata[2])
      begin
         flags_next[`CRSF_F_N] = res[15]; // see [RQ11]
         flags_next[`CRSF_F_Z] = (res[15:0] == 16'h0000); // see [RQ12]
      end
      else
      begin
         flags_next[`CRSF_F_N] = res[7]; // see [RQ11]
         flags_next[`CRSF_F_Z] = (res[7:0] == 8'h00); // see [RQ12]
      end
   end
   // ------------------------------------------------------------
   // bank mapping
   // ------------------------------------------------------------
   assign gpr_index = {bank_reg[4:0], gsel_reg}; // see [RQ16] see [RQ17]
   assign o_gpr_address = `CRSF_GPR_BASE + {8'h00, gpr_index}; // see [RQ18]
   // ------------------------------------------------------------
   // interrupt admission
   // ------------------------------------------------------------
   assign o_irq_accept = i_irq_req && flags_reg[`CRSF_F_I] && // see [RQ9]
      (crsf_rank(i_irq_level) < crsf_rank(flags_reg[`CRSF_F_IL1:`CRSF_F_IL0])); // see [RQ10]
   assign o_program_counter = pc_reg;
   // ------------------------------------------------------------
   // write side
   // ------------------------------------------------------------
   always @(posedge i_clock)
   begin
      if (!i_rstn)
      begin
         pc_reg    <= `CRSF_RST_WORD; // see [RQ19]
         acc_reg   <= `CRSF_RST_WORD;
         tmp_reg   <= `CRSF_RST_WORD;
         idx_reg   <= `CRSF_RST_WORD;
         ext_reg   <= `CRSF_RST_WORD;
         sp_reg    <= `CRSF_RST_WORD;
         bank_reg  <= 8'h00;
         flags_reg <= `CRSF_RST_FLAGS; // see [RQ9]
         gsel_reg  <= 3'h0;
      end
      else if (i_wr)
      begin
         if (i_addr == `CRSF_ADDR_PC)
            pc_reg <= i_wdata; // see [RQ1]
         else if (i_addr == `CRSF_ADDR_ACC)
            acc_reg <= i_wdata; // see [RQ2]
         else if (i_addr == `CRSF_ADDR_TMP)
            tmp_reg <= i_wdata; // see [RQ3]
         else if (i_addr == `CRSF_ADDR_IDX)
            idx_reg <= i_wdata; // see [RQ4]
         else if (i_addr == `CRSF_ADDR_EXT)
            ext_reg <= i_wdata; // see [RQ5]
         else if (i_addr == `CRSF_ADDR_SP)
            sp_reg <= i_wdata; // see [RQ6]
         else if (i_addr == `CRSF_ADDR_PS)
         begin
            bank_reg  <= i_wdata[15:8]; // see [RQ7]
            flags_reg <= i_wdata[7:0];
         end
         else if (i_addr == `CRSF_ADDR_CTRL)
         begin
            if (i_wdata[2])
               acc_reg <= res[15:0];
            else
               acc_reg <= {acc_reg[15:8], res[7:0]}; // see [RQ2]
            flags_reg <= flags_next;
         end
         else if (i_addr == `CRSF_ADDR_GPR)
            gsel_reg <= i_wdata[10:8];
      end
   end
   // ------------------------------------------------------------
   // general register memory
   // ------------------------------------------------------------
   always @(posedge i_clock)
   begin
      if (i_wr && (i_addr == `CRSF_ADDR_GPR))
         gpr_mem[{bank_reg[4:0], i_wdata[10:8]}] <= i_wdata[7:0]; // see [RQ16]
   end
   // ------------------------------------------------------------
   // read side
   // ------------------------------------------------------------
   always @(posedge i_clock)
   begin
      if (!i_rstn)
         o_rdata <= 16'h0000;
      else if (i_rd)
      begin
         if (i_addr == `CRSF_ADDR_PC)
            o_rdata <= pc_reg;
         else if (i_addr == `CRSF_ADDR_ACC)
            o_rdata <= acc_reg;
         else if (i_addr == `CRSF_ADDR_TMP)
            o_rdata <= tmp_reg;
         else if (i_addr == `CRSF_ADDR_IDX)
            o_rdata <= idx_reg;
         else if (i_addr == `CRSF_ADDR_EXT)
            o_rdata <= ext_reg;
         else if (i_addr == `CRSF_ADDR_SP)
            o_rdata <= sp_reg;
         else if (i_addr == `CRSF_ADDR_PS)
            o_rdata <= {bank_reg, flags_reg};
         else if (i_addr == `CRSF_ADDR_GPR)
            o_rdata <= {5'h00, gsel_reg, gpr_mem[gpr_index]};
         else if (i_addr == `CRSF_ADDR_IRQ)
            o_rdata <= {15'h0000, o_irq_accept};
         else
            o_rdata <= 16'h0000;
      end
      else
         o_rdata <= 16'h0000;
   end
endmodule

// File: inc/crsf_defines.vh
// Functional notes
// [RQ1] 16-bit program counter holds fetch address
// [RQ2] 16-bit accumulator; byte ops use low byte
// [RQ3] 16-bit temp accumulator is second operand
// [RQ4] 16-bit index pointer modifies addresses
// [RQ5] 16-bit extra pointer addresses any location
// [RQ6] 16-bit stack pointer marks stack position
// [RQ7] status upper byte bank pointer, lower flags
// [RQ8] half-carry on carry/borrow bit3 to bit4
// [RQ9] interrupt enable gates interrupts; reset clears
// [RQ10] level mask admits only higher-ranked requests
// [RQ11] negative flag copies result msb
// [RQ12] zero flag set on zero result
// [RQ13] overflow flag on signed overflow
// [RQ14] carry flag on carry/borrow at bit7
// [RQ15] shifts load carry with shifted-out bit
// [RQ16] 32 banks of eight 8-bit general registers
// [RQ17] bank pointer selects active general bank
// [RQ18] bank-to-address mapping is a parameterised base
// [RQ19] other dedicated registers reset undefined (zero here)
`ifndef CRSF_DEFINES_VH
`define CRSF_DEFINES_VH
// register indices
`define CRSF_ADDR_PC      4'h0
`define CRSF_ADDR_ACC     4'h1
`define CRSF_ADDR_TMP     4'h2
`define CRSF_ADDR_IDX     4'h3
`define CRSF_ADDR_EXT     4'h4
`define CRSF_ADDR_SP      4'h5
`define CRSF_ADDR_PS      4'h6
`define CRSF_ADDR_CTRL    4'h7
`define CRSF_ADDR_GPR     4'h8
`define CRSF_ADDR_IRQ     4'h9
// condition flag bit positions
`define CRSF_F_C          0
`define CRSF_F_V          1
`define CRSF_F_Z          2
`define CRSF_F_N          3
`define CRSF_F_IL0        4
`define CRSF_F_IL1        5
`define CRSF_F_I          6
`define CRSF_F_H          7
// alu operations
`define CRSF_OP_ADD       3'h0
`define CRSF_OP_SUB       3'h1
`define CRSF_OP_SHL       3'h2
`define CRSF_OP_SHR       3'h3
`define CRSF_OP_ADDW      3'h4
`define CRSF_OP_SUBW      3'h5
// reset values and general register base
`define CRSF_RST_WORD     16'h0000
`define CRSF_RST_FLAGS    8'h30
`define CRSF_GPR_BASE     16'h0100
`endif
